// File: sdf_pkg.sv
// Purpose: Constants and carrier types for the slave diagnostic frame builder
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes: Byte positions are offsets into the outgoing diagnostic datagram
package sdf_pkg;
   localparam int unsigned POS_STAT0 = 0;
   localparam int unsigned POS_STAT1 = 1;
   localparam int unsigned POS_STAT2 = 2;
   localparam int unsigned POS_MASTER = 3;
   localparam int unsigned POS_ID_HI = 4;
   localparam int unsigned POS_ID_LO = 5;
   localparam int unsigned POS_IDENT = 6;
   localparam int unsigned IDENT_LEN = 1;
   localparam int unsigned MOD_MAX = 13;
   localparam int unsigned INT_MAX = 20;
   localparam int unsigned INT_TYPE_OFS = 1;
   localparam int unsigned INT_DATA_OFS = 4;
   localparam int unsigned INT_INFO_LEN = 4;
   localparam int unsigned DIAG_ZERO_FIRST = 8;
   localparam int unsigned FRAME_MAX = 40;
   localparam int unsigned OVF_BIT = 7;
   localparam logic [7:0] STAT2_RESET = 8'h00;
   localparam logic [7:0] MASTER_NONE = 8'hFF;
   localparam logic [7:0] CODE_PROC = 8'h02;
   localparam logic [7:0] CODE_DIAG = 8'h01;
   localparam logic [7:0] HDR_LEN_BYTE = 8'h14;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Vendor identity; value is arbitrary
   localparam logic [15:0] VENDOR_ID_DEFAULT = 16'h5A5A;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } sdf_byte_type;

   typedef struct packed {
      logic [31:0] info;
   } sdf_alarm_type;
endpackage : sdf_pkg

// File: sdf_frame_builder.sv
// Purpose: Builds and streams the slave diagnostic datagram to the bus master side
// Assumes: Request and byte-ready come from logic on the same clock
// Notes: Frame is latched at request time, then streamed one byte per accepted cycle
`timescale 1ns/1ps

// Functional notes
// RL1 - Station status byte 0 at position 0, byte 1 at position 1.
// RL2 - Bits 0 to 6 of third station status byte are always zero.
// RL3 - Bit 7 of third status byte set when diagnostic messages overflow storage.
// RL4 - Byte 3 holds the full address of the configuring master.
// RL5 - Byte 3 reads FF while no master has configured the slave.
// RL6 - Bytes 4 and 5 carry vendor identity, high byte first.
// RL7 - Identifier diagnostics flag which address ranges received an entry.
// RL8 - Module status starts with module diagnostics, at most thirteen bytes.
// RL9 - Interrupt status section starts at byte y, at most twenty bytes.
// RL10 - Process interrupt writes type code 02 into byte y+1.
// RL11 - Process interrupt carries exactly four info bytes from y+4.
// RL12 - Diagnostic interrupt writes type code 01 into byte y+1.
// RL13 - Diagnostic interrupt carries sixteen bytes; y+8 to y+19 are zero.
// RL14 - Operating state change raises a diagnostic interrupt.
// RL15 - Alarm-send block request raises a diagnostic interrupt.
// RL16 - Diagnostic bytes follow data record zero; unused bits read zero.
// RL17 - Bytes go out ascending; master reads whole datagram before acting.
module sdf_frame_builder #(
   parameter logic [15:0] VENDOR_ID = sdf_pkg::VENDOR_ID_DEFAULT
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] stat0_i,
   input wire logic [7:0] stat1_i,
   input wire logic diag_overflow_i,
   input wire logic master_valid_i,
   input wire logic [7:0] master_addr_i,
   input wire logic [7:0] range_hit_i,
   input wire logic [3:0] mod_len_i,
   input wire logic [7:0] mod_status_i [0:12],
   input wire logic op_state_i,
   input wire logic alarm_send_i,
   input wire logic process_alarm_i,
   input wire sdf_pkg::sdf_alarm_type alarm_info_i,
   input wire logic [31:0] record0_i,
   input wire logic [31:0] record0_used_i,
   input wire logic req_i,
   input wire logic byte_ready_i,
   output logic byte_valid_o,
   output sdf_pkg::sdf_byte_type byte_o,
   output logic alarm_pending_o
);
   typedef enum logic [1:0] {INT_NONE, INT_PROC, INT_DIAG} sdf_int_type;
   typedef enum logic {ST_IDLE, ST_SEND} sdf_state_type;

   logic [7:0] frame [0:sdf_pkg::FRAME_MAX-1];
   logic [5:0] frame_len;
   logic [5:0] rd_ptr;
   sdf_state_type state;
   sdf_int_type pend_kind;
   logic [31:0] pend_info;
   logic op_state_q;
   logic next_diag_evt;
   logic [5:0] y_pos;
   logic [3:0] mod_len_c;
   logic [31:0] rec_masked;
   logic take;

   assign take = (state == ST_IDLE) && req_i;
   assign mod_len_c = (mod_len_i > 4'(sdf_pkg::MOD_MAX)) ? 4'(sdf_pkg::MOD_MAX) : mod_len_i; // RL8
   assign y_pos = 6'(sdf_pkg::POS_IDENT + sdf_pkg::IDENT_LEN) + {2'b00, mod_len_c}; // RL9
   assign rec_masked = record0_i & record0_used_i; // RL16
   assign next_diag_evt = (op_state_i != op_state_q) || alarm_send_i; // RL14 RL15

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         // Track the level during reset so its release raises no false event
         op_state_q <= op_state_i;
      end else begin
         op_state_q <= op_state_i;
      end
   end

   // Pending alarm: a new event wins over the clear caused by reporting it
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pend_kind <= INT_NONE;
         pend_info <= 32'h0000_0000;
      end else if (next_diag_evt) begin
         pend_kind <= INT_DIAG; // RL14 RL15
         pend_info <= rec_masked; // RL16
      end else if (process_alarm_i) begin
         pend_kind <= INT_PROC;
         pend_info <= alarm_info_i.info; // RL11
      end else if (take) begin
         pend_kind <= INT_NONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         for (int i = 0; i < sdf_pkg::FRAME_MAX; i++) begin
            frame[i] <= 8'h00;
         end
         frame_len <= 6'd0;
      end else if (take) begin
         for (int i = 0; i < sdf_pkg::FRAME_MAX; i++) begin
            frame[i] <= sdf_pkg::ZERO_BYTE;
         end
         frame[sdf_pkg::POS_STAT0] <= stat0_i; // RL1
         frame[sdf_pkg::POS_STAT1] <= stat1_i; // RL1
         frame[sdf_pkg::POS_STAT2] <= sdf_pkg::STAT2_RESET | {diag_overflow_i, 7'b000_0000}; // RL2 RL3
         frame[sdf_pkg::POS_MASTER] <= master_valid_i ? master_addr_i : sdf_pkg::MASTER_NONE; // RL4 RL5
         frame[sdf_pkg::POS_ID_HI] <= VENDOR_ID[15:8]; // RL6
         frame[sdf_pkg::POS_ID_LO] <= VENDOR_ID[7:0]; // RL6
         frame[sdf_pkg::POS_IDENT] <= range_hit_i; // RL7
         for (int i = 0; i < sdf_pkg::MOD_MAX; i++) begin
            if (4'(i) < mod_len_c) begin
               frame[sdf_pkg::POS_IDENT + sdf_pkg::IDENT_LEN + i] <= mod_status_i[i]; // RL8
            end
         end
         if (pend_kind == INT_NONE) begin
            frame_len <= y_pos;
         end else begin
            frame[y_pos] <= sdf_pkg::HDR_LEN_BYTE;
            frame[y_pos + 6'(sdf_pkg::INT_TYPE_OFS)] <=
               (pend_kind == INT_PROC) ? sdf_pkg::CODE_PROC : sdf_pkg::CODE_DIAG; // RL10 RL12
            for (int i = 0; i < sdf_pkg::INT_INFO_LEN; i++) begin
               frame[y_pos + 6'(sdf_pkg::INT_DATA_OFS + i)] <= pend_info[31-8*i -: 8]; // RL11 RL16
            end
            // Bytes y+8 to y+19 stay zero from the clear above
            frame_len <= y_pos + 6'(sdf_pkg::INT_MAX); // RL9 RL13
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
         rd_ptr <= 6'd0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (req_i) begin
                  state <= ST_SEND;
                  rd_ptr <= 6'd0;
               end
            end
            ST_SEND: begin
               if (byte_ready_i) begin
                  if (rd_ptr == frame_len - 6'd1) begin
                     state <= ST_IDLE;
                  end else begin
                     rd_ptr <= rd_ptr + 6'd1; // RL17
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   assign byte_valid_o = (state == ST_SEND);
   assign byte_o = '{data: frame[rd_ptr], last: (state == ST_SEND) && (rd_ptr == frame_len - 6'd1)};
   assign alarm_pending_o = (pend_kind != INT_NONE);

   property p_stat2_zero;
      @(posedge clk_i) disable iff (srst_i) byte_valid_o && rd_ptr == 6'd2 |-> byte_o.data[6:0] == 7'h00;
   endproperty
   a_stat2_zero: assert property (p_stat2_zero) else $error("status byte 2 low bits nonzero"); // RL2

   property p_ovf;
      @(posedge clk_i) disable iff (srst_i) take && diag_overflow_i |=> frame[2][7];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow bit missing"); // RL3

   property p_master_none;
      @(posedge clk_i) disable iff (srst_i) take && !master_valid_i |=> frame[3] == 8'hFF;
   endproperty
   a_master_none: assert property (p_master_none) else $error("unconfigured master not FF"); // RL5

   property p_master_addr;
      @(posedge clk_i) disable iff (srst_i) take && master_valid_i |=> frame[3] == $past(master_addr_i);
   endproperty
   a_master_addr: assert property (p_master_addr) else $error("master address wrong"); // RL4

   property p_vendor;
      @(posedge clk_i) disable iff (srst_i) take |=> frame[4] == VENDOR_ID[15:8] && frame[5] == VENDOR_ID[7:0];
   endproperty
   a_vendor: assert property (p_vendor) else $error("vendor bytes wrong"); // RL6

   property p_len;
      @(posedge clk_i) disable iff (srst_i) take && pend_kind == INT_NONE |=>
         frame_len == $past(y_pos) && frame_len <= 6'(sdf_pkg::POS_IDENT + sdf_pkg::IDENT_LEN + sdf_pkg::MOD_MAX);
   endproperty
   a_len: assert property (p_len) else $error("frame too long"); // RL8

   property p_diag_evt;
      @(posedge clk_i) disable iff (srst_i) alarm_send_i |=> pend_kind == INT_DIAG;
   endproperty
   a_diag_evt: assert property (p_diag_evt) else $error("alarm send not pending"); // RL15

   property p_state_evt;
      @(posedge clk_i) disable iff (srst_i) $changed(op_state_i) && !$past(srst_i) |=> alarm_pending_o;
   endproperty
   a_state_evt: assert property (p_state_evt) else $error("state change not pending"); // RL14

   sequence s_start;
      take && pend_kind == INT_PROC;
   endsequence
   property p_proc_code;
      @(posedge clk_i) disable iff (srst_i) s_start |=> frame[$past(y_pos) + 6'd1] == 8'h02;
   endproperty
   a_proc_code: assert property (p_proc_code) else $error("process code wrong"); // RL10

   property p_proc_info;
      @(posedge clk_i) disable iff (srst_i) s_start |=> frame[$past(y_pos) + 6'd4] == $past(pend_info[31:24]);
   endproperty
   a_proc_info: assert property (p_proc_info) else $error("process info byte wrong"); // RL11

   sequence s_diag_start;
      take && pend_kind == INT_DIAG;
   endsequence
   property p_diag_code;
      @(posedge clk_i) disable iff (srst_i) s_diag_start |=> frame[$past(y_pos) + 6'd1] == sdf_pkg::CODE_DIAG;
   endproperty
   a_diag_code: assert property (p_diag_code) else $error("diagnostic code wrong"); // RL12

   property p_diag_tail;
      @(posedge clk_i) disable iff (srst_i) s_diag_start |=>
         frame[$past(y_pos) + 6'd8] == sdf_pkg::ZERO_BYTE && frame[$past(y_pos) + 6'd19] == sdf_pkg::ZERO_BYTE;
   endproperty
   a_diag_tail: assert property (p_diag_tail) else $error("diagnostic tail not zero"); // RL13

   property p_ascend;
      @(posedge clk_i) disable iff (srst_i) byte_valid_o && byte_ready_i && !byte_o.last |=>
         byte_valid_o && rd_ptr == $past(rd_ptr) + 6'd1;
   endproperty
   a_ascend: assert property (p_ascend) else $error("bytes not ascending"); // RL17
endmodule : sdf_frame_builder

// File: sdf_master_model.sv
// Purpose: Bus master model that requests and reads one diagnostic datagram
// Assumes: Same clock as the frame builder
// Notes: Accepts a byte only every other cycle to exercise stalls
`timescale 1ns/1ps
module sdf_master_model (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic go_i,
   input wire logic byte_valid_i,
   input wire sdf_pkg::sdf_byte_type byte_i,
   output logic req_o,
   output logic byte_ready_o,
   output logic [7:0] rx_o [0:39],
   output int rx_n_o,
   output logic done_o
);
   always_ff @(posedge clk_i) begin
      req_o <= go_i;
      byte_ready_o <= srst_i ? 1'b0 : ~byte_ready_o;
      done_o <= 1'b0;
      if (go_i) begin
         rx_n_o <= 0;
      end
      // Frame is only reported whole, after the last byte
      if (byte_valid_i && byte_ready_o) begin
         rx_o[rx_n_o] <= byte_i.data;
         rx_n_o <= rx_n_o + 1;
         done_o <= byte_i.last;
      end
   end
endmodule : sdf_master_model

// File: sdf_frame_builder_tb.sv
// Purpose: Self-checking bench for the diagnostic frame builder
// Assumes: Master model reads each frame with stalls
// Notes: Expected frames are rebuilt from the bench's own inputs
`timescale 1ns/1ps
module sdf_frame_builder_tb;
   localparam logic [15:0] VID = 16'hC396; // Identity value is arbitrary
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] s0 = 8'h00, s1 = 8'h00, ma = 8'h00, rh = 8'h00;
   logic ovf = 1'b0, mv = 1'b0, ops = 1'b0, asend = 1'b0, palm = 1'b0, go = 1'b0;
   logic [3:0] mlen = 4'h0;
   logic [7:0] ms [0:12];
   sdf_pkg::sdf_alarm_type ainfo = '0;
   logic [31:0] rec = 32'h0000_0000, used = 32'h0000_0000;
   logic req, rdy, valid, pend, done;
   sdf_pkg::sdf_byte_type b;
   logic [7:0] rx [0:39];
   logic [7:0] ex [0:39];
   int rx_n, ex_n, failures = 0, n_compared = 0, cyc = 0;
   initial forever #50 clk_i = ~clk_i;
   initial for (int i = 0; i < 13; i++) ms[i] = 8'(i + 48);
   sdf_frame_builder #(.VENDOR_ID(VID)) i_dut (.clk_i(clk_i), .srst_i(srst_i), .stat0_i(s0), .stat1_i(s1),
      .diag_overflow_i(ovf), .master_valid_i(mv), .master_addr_i(ma), .range_hit_i(rh), .mod_len_i(mlen),
      .mod_status_i(ms), .op_state_i(ops), .alarm_send_i(asend), .process_alarm_i(palm),
      .alarm_info_i(ainfo), .record0_i(rec), .record0_used_i(used), .req_i(req), .byte_ready_i(rdy),
      .byte_valid_o(valid), .byte_o(b), .alarm_pending_o(pend));
   sdf_master_model i_master (.clk_i(clk_i), .srst_i(srst_i), .go_i(go), .byte_valid_i(valid), .byte_i(b),
      .req_o(req), .byte_ready_o(rdy), .rx_o(rx), .rx_n_o(rx_n), .done_o(done));
   task automatic tally_and_finish();
      $display("compared %0d, failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic read_frame(input logic [7:0] code, input logic [31:0] info);
      int m;
      int w;
      m = (mlen > 13) ? 13 : int'(mlen);
      ex[0] = s0;
      ex[1] = s1;
      ex[2] = {ovf, 7'h00};
      ex[3] = mv ? ma : 8'hFF;
      ex[4] = VID[15:8];
      ex[5] = VID[7:0];
      ex[6] = rh;
      for (int i = 0; i < m; i++) ex[7 + i] = ms[i];
      ex_n = 7 + m;
      if (code !== 8'h00) begin
         for (int i = 0; i < 20; i++) ex[ex_n + i] = 8'h00;
         ex[ex_n] = sdf_pkg::HDR_LEN_BYTE;
         ex[ex_n + 1] = code;
         for (int i = 0; i < 4; i++) ex[ex_n + 4 + i] = info[31 - 8 * i -: 8];
         ex_n += 20;
      end
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      w = 0;
      while (done !== 1'b1 && w < 300) begin
         @(posedge clk_i);
         #1;
         w++;
      end
      if (w >= 300) begin
         failures++;
         $display("CHECK FAILED at %0t: frame never completed", $time);
      end
      check(8'(rx_n), 8'(ex_n));
      for (int i = 0; i < ex_n; i++) check(rx[i], ex[i]);
      // Return on a rising edge so the caller's next stimulus lands on it
      @(posedge clk_i);
   endtask : read_frame
   initial begin
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      read_frame(8'h00, 32'h0000_0000);
      $display("test 1 done");
      s0 <= 8'h81;
      s1 <= 8'h0C;
      ovf <= 1'b1;
      mv <= 1'b1;
      ma <= 8'h2C;
      rh <= 8'hA5;
      mlen <= 4'hD;
      ainfo.info <= 32'h1122_3344;
      palm <= 1'b1;
      @(posedge clk_i);
      palm <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check({7'h00, pend}, 8'h01);
      read_frame(8'h02, 32'h1122_3344);
      @(negedge clk_i);
      check({7'h00, pend}, 8'h00);
      @(posedge clk_i);
      $display("test 2 done");
      mlen <= 4'hF;
      rec <= 32'hDEAD_BEEF;
      used <= 32'hFF0F_00F0;
      asend <= 1'b1;
      @(posedge clk_i);
      asend <= 1'b0;
      repeat (2) @(posedge clk_i);
      read_frame(8'h01, 32'hDE0D_00E0);
      $display("test 3 done");
      ops <= 1'b1;
      repeat (3) @(posedge clk_i);
      read_frame(8'h01, 32'hDE0D_00E0);
      read_frame(8'h00, 32'h0000_0000);
      $display("test 4 done");
      tally_and_finish();
   end
endmodule : sdf_frame_builder_tb
